/* File: flash_write_status_polling_tb_top.sv */
// Top bench for the flash status polling host.
// Assumes the behavioural flash model on the far side.
`timescale 1ns/1ns
module flash_write_status_polling_tb_top;
  import fwsp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] mode = 2'd0;
  logic wbit = 1'b1;
  logic tmo = 1'b0;
  logic [31:0] rdata_out;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] fdata;
  logic ce_n, oe_n, rb_n;
  logic busy;
  int n_errors = 0;
  int compares = 0;
  fwsp_host uut (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .flash_addr_out(faddr), .flash_ce_n_out(ce_n),
    .flash_oe_n_out(oe_n), .flash_we_n_out(), .flash_data_in(fdata),
    .flash_data_out(), .flash_data_oe_out(), .ready_busy_in_n(rb_n),
    .busy_out(busy));
  fwsp_flash_model dev (.ce_n_in(ce_n), .oe_n_in(oe_n), .addr_in(faddr),
    .mode_in(mode), .wbit_in(wbit), .tmo_in(tmo), .data_out(fdata),
    .rb_n_out(rb_n));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(REG_STAT, s);
      if (s[ST_BUSY] === 1'b0) return;
    end
    n_errors++;
    give_verdict();
  endtask
  task automatic t_program_poll();
    logic [31:0] s;
    mode <= 2'd1;
    wr(REG_ADDR, 32'h10);
    wr(REG_DATA, 32'h80);
    wr(REG_CTRL, 32'h1);
    repeat (60) @(posedge clk_in);
    rd(REG_STAT, s);
    check({30'h0, s[1:0]}, 32'h1);
    check({31'h0, busy}, 32'h1);
    rd(REG_LAST, s);
    check({31'h0, s[POLL_BIT]}, 32'h0);
    rd(REG_DATA, s);
    check(s, 32'h1);
    check(32'(faddr), 32'h10);
    mode <= 2'd0;
    wait_idle();
    rd(REG_STAT, s);
    check({26'h0, s[5:0]}, 32'h0a);
    rd(REG_LAST, s);
    check(s, 32'h95);
    check({31'h0, busy}, 32'h0);
  endtask
  task automatic t_erase_toggle();
    logic [31:0] s;
    mode <= 2'd2;
    wr(REG_ADDR, 32'h800000);
    wr(REG_CTRL, 32'h2);
    repeat (40) @(posedge clk_in);
    rd(REG_STAT, s);
    check({29'h0, s[4], s[3], s[0]}, 32'h5);
    mode <= 2'd3;
    wait_idle();
    rd(REG_STAT, s);
    check({26'h0, s[5:0]}, 32'h0a);
  endtask
  task automatic t_timeout();
    logic [31:0] s;
    mode <= 2'd1;
    tmo <= 1'b1;
    wr(REG_CTRL, 32'h2);
    wait_idle();
    rd(REG_STAT, s);
    check({30'h0, s[2], s[0]}, 32'h2);
    mode <= 2'd0; // Reset command
    tmo <= 1'b0;
  endtask
  task automatic t_reset_mid();
    logic [31:0] s;
    mode <= 2'd1;
    wr(REG_CTRL, 32'h1);
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 check({31'h0, ce_n}, 32'h1);
    rd(REG_STAT, s);
    check({29'h0, s[2:0]}, 32'h0);
    rd(REG_ADDR, s);
    check(s, 32'h0);
    mode <= 2'd0;
  endtask
  task automatic t_abort();
    logic [31:0] s;
    mode <= 2'd1;
    wr(REG_DATA, 32'h80);
    wr(REG_CTRL, 32'h1);
    repeat (20) @(posedge clk_in);
    wr(REG_CTRL, 32'h4);
    wait_idle();
    rd(REG_STAT, s);
    check({29'h0, s[2:0]}, 32'h0);
    mode <= 2'd0;
  endtask
  task automatic t_program_protected();
    logic [31:0] s;
    mode <= 2'd1;
    wr(REG_CTRL, 32'h2);
    repeat (50) @(posedge clk_in);
    mode <= 2'd0;
    wait_idle();
    rd(REG_STAT, s);
    check({29'h0, s[2:0]}, 32'h2);
  endtask
  task automatic t_erase_protected();
    logic [31:0] s;
    mode <= 2'd2;
    wr(REG_ADDR, 32'h800000);
    wr(REG_DATA, 32'h80);
    wr(REG_CTRL, 32'h1);
    repeat (2500) @(posedge clk_in);
    rd(REG_LAST, s);
    check({31'h0, s[POLL_BIT]}, 32'h0);
    mode <= 2'd0;
    wait_idle();
    rd(REG_STAT, s);
    check({29'h0, s[2:0]}, 32'h2);
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_program_poll();
    t_erase_toggle();
    t_timeout();
    t_reset_mid();
    t_abort();
    t_program_protected();
    t_erase_protected();
    give_verdict();
  end
endmodule

/* File: fwsp_flash_model.sv */
// Behavioural flash answering status reads.
// Assumes chip select and output enable rise together.
`timescale 1ns/1ns
module fwsp_flash_model (
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [1:0] mode_in,
  input wire logic wbit_in,
  input wire logic tmo_in,
  output logic [7:0] data_out,
  output logic rb_n_out
);
  // Modes: 0 array, 1 program, 2 erase, 3 erase suspended
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] stat;
  always_comb begin
    case (mode_in)
      2'd0: stat = {wbit_in, 7'h15};
      2'd1: stat = {~wbit_in, t1, tmo_in, 5'h00};
      2'd2: stat = {1'b0, t1, tmo_in, 2'b01, t2, 2'b00};
      default: stat = {1'b1, t1, 3'b000, t2, 2'b00};
    endcase
  end
  always @(posedge (ce_n_in | oe_n_in)) begin
    last = stat;
    if (mode_in == 2'd1 || mode_in == 2'd2) t1 = ~t1;
    if (mode_in[1] && addr_in[23]) t2 = ~t2;
  end
  // Released bus shows the inverse of the last byte
  assign data_out = (!ce_n_in && !oe_n_in) ? stat : ~last;
  assign rb_n_out = !(mode_in == 2'd1 || mode_in == 2'd2);
endmodule

/* File: fwsp_host.sv */
// Host controller that polls flash write status over the parallel bus.
// Assumes software has already issued the program or erase command and
// that flash data and ready/busy come from outside the clock domain.
`timescale 1ns/1ns
module fwsp_host (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic [fwsp_pkg::ADDR_W-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  input wire logic [fwsp_pkg::DATA_W-1:0] flash_data_in,
  output logic [fwsp_pkg::DATA_W-1:0] flash_data_out,
  output logic flash_data_oe_out,
  input wire logic ready_busy_in_n,
  output logic busy_out
);
  import fwsp_pkg::*;

  // Elaboration checks on widths and counter reach
  if (DATA_W < 8) begin
    $error("Data width too small for status bits");
  end
  if (READ_CYCLES > 15 || RECOVER_CYCLES + 2 > 15) begin
    $error("Read timing does not fit the cycle counter");
  end

  logic [DATA_W-1:0] data_meta, data_sync;
  logic rb_meta, rb_sync;
  fwsp_state_type state, next_state;
  fwsp_mode_type mode, next_mode;
  logic [ADDR_W-1:0] poll_addr, next_poll_addr;
  logic expect_bit, next_expect_bit;
  logic [3:0] cnt, next_cnt;
  logic [DATA_W-1:0] last, next_last;
  logic [DATA_W-1:0] sample, next_sample;
  logic abort_req, next_abort_req;
  logic have_first, next_have_first;
  logic saw_timeout, next_saw_timeout;
  logic done, next_done;
  logic fail, next_fail;
  logic ce_n, next_ce_n;
  logic oe_n, next_oe_n;
  logic [31:0] rdata, next_rdata;

  // Pin inputs pass two flip-flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_meta <= '0;
      data_sync <= '0;
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
    end else begin
      data_meta <= flash_data_in;
      data_sync <= data_meta;
      rb_meta <= ready_busy_in_n;
      rb_sync <= rb_meta;
    end
  end

  function automatic logic toggled(input logic [DATA_W-1:0] a,
                                   input logic [DATA_W-1:0] b);
    toggled = a[TOGGLE_ONE_BIT] != b[TOGGLE_ONE_BIT];
  endfunction

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_poll_addr = poll_addr;
    next_expect_bit = expect_bit;
    next_cnt = cnt;
    next_last = last;
    next_sample = sample;
    next_abort_req = abort_req;
    next_have_first = have_first;
    next_saw_timeout = saw_timeout;
    next_done = done;
    next_fail = fail;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_rdata = 32'h0;
    if (rd_in) begin
      unique case (addr_in)
        REG_ADDR: next_rdata = 32'(poll_addr);
        REG_DATA: next_rdata = {31'h0, expect_bit};
        REG_STAT: begin
          next_rdata[ST_BUSY] = state != FWSP_IDLE;
          next_rdata[ST_DONE] = done;
          next_rdata[ST_FAIL] = fail;
          next_rdata[ST_RDY] = rb_sync;
          next_rdata[ST_ERTIMER] = last[ERASE_TIMER_BIT];
          next_rdata[ST_ABORTBIT] = last[ABORT_BIT];
        end
        REG_LAST: next_rdata = 32'(last);
        default: next_rdata = 32'h0;
      endcase
    end
    if (wr_in && state == FWSP_IDLE) begin
      unique case (addr_in)
        REG_ADDR: next_poll_addr = wdata_in[ADDR_W-1:0];
        REG_DATA: next_expect_bit = wdata_in[POLL_BIT];
        REG_CTRL: begin
          if (wdata_in[CTRL_POLL] || wdata_in[CTRL_TOGGLE]) begin
            next_mode = wdata_in[CTRL_TOGGLE] ? FWSP_MODE_TOGGLE
                                              : FWSP_MODE_POLL;
            next_have_first = 1'b0;
            next_saw_timeout = 1'b0;
            next_done = 1'b0;
            next_fail = 1'b0;
            next_state = FWSP_SETUP;
          end
        end
        default: ;
      endcase
    end
    // Abort is held until the next evaluation
    if (wr_in && addr_in == REG_CTRL && wdata_in[CTRL_ABORT] &&
        state != FWSP_IDLE) begin
      next_abort_req = 1'b1;
    end
    unique case (state)
      FWSP_IDLE: ;
      FWSP_SETUP: begin
        next_ce_n = 1'b0;
        next_oe_n = 1'b0;
        next_cnt = 4'(READ_CYCLES);
        next_state = FWSP_STROBE;
      end
      FWSP_STROBE: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          // Bus seen two edges back, still inside the strobe
          next_sample = data_sync;
          // Each read ends with strobes released
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = 4'(RECOVER_CYCLES + 2);
          next_state = FWSP_RECOVER;
        end
      end
      FWSP_RECOVER: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_state = FWSP_EVAL;
        end
      end
      FWSP_EVAL: begin
        next_last = sample;
        next_have_first = 1'b1;
        next_state = FWSP_SETUP;
        if (next_abort_req) begin
          next_state = FWSP_IDLE;
        end else if (mode == FWSP_MODE_POLL) begin
          if (sample[POLL_BIT] == expect_bit) begin
            // Confirm with a further read before trusting data
            if (have_first && last[POLL_BIT] == expect_bit) begin
              next_done = 1'b1;
              next_state = FWSP_IDLE;
            end
          end else if (saw_timeout) begin
            next_fail = 1'b1;
            next_state = FWSP_IDLE;
          end else if (sample[TIMEOUT_BIT]) begin
            next_saw_timeout = 1'b1;
          end
        end else if (have_first) begin
          if (!toggled(sample, last)) begin
            next_done = 1'b1;
            next_state = FWSP_IDLE;
          end else if (saw_timeout) begin
            next_fail = 1'b1;
            next_state = FWSP_IDLE;
          end else if (sample[TIMEOUT_BIT]) begin
            next_saw_timeout = 1'b1;
          end
        end
      end
      default: next_state = FWSP_IDLE;
    endcase
    if (next_state == FWSP_IDLE) begin
      next_abort_req = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= FWSP_IDLE;
      mode <= FWSP_MODE_POLL;
      poll_addr <= '0;
      expect_bit <= 1'b0;
      cnt <= 4'h0;
      last <= '0;
      sample <= '0;
      abort_req <= 1'b0;
      have_first <= 1'b0;
      saw_timeout <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      poll_addr <= next_poll_addr;
      expect_bit <= next_expect_bit;
      cnt <= next_cnt;
      last <= next_last;
      sample <= next_sample;
      abort_req <= next_abort_req;
      have_first <= next_have_first;
      saw_timeout <= next_saw_timeout;
      done <= next_done;
      fail <= next_fail;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      rdata <= next_rdata;
    end
  end

  logic busy;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy <= 1'b0;
    end else begin
      busy <= !rb_sync;
    end
  end

  assign rdata_out = rdata;
  assign flash_addr_out = poll_addr;
  assign flash_ce_n_out = ce_n;
  assign flash_oe_n_out = oe_n;
  assign flash_we_n_out = 1'b1;
  assign flash_data_out = '0;
  assign flash_data_oe_out = 1'b0;
  assign busy_out = busy;
endmodule

/* File: fwsp_monitor.sv */
// Checker of the host's flash read cycles and register answers.
// Assumes it is bound onto fwsp_host.
`timescale 1ns/1ns
module fwsp_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [fwsp_pkg::ADDR_W-1:0] flash_addr_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_data_oe_out,
  input wire logic ready_busy_in_n,
  input wire logic busy_out
);
  import fwsp_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_ADDR_HELD: assert property (
    !flash_ce_n_out && !$past(flash_ce_n_out) |-> $stable(flash_addr_out))
    else $error("address moved");
  AST_OE_WITH_CE: assert property (flash_oe_n_out == flash_ce_n_out)
    else $error("strobes apart");
  AST_STROBE_LEN: assert property (
    $fell(flash_ce_n_out) |-> !flash_ce_n_out [*5] ##1 flash_ce_n_out)
    else $error("strobe length");
  AST_RECOVER_GAP: assert property (
    $rose(flash_ce_n_out) |-> flash_ce_n_out [*4])
    else $error("reads too close");
  AST_NO_WRITE: assert property (flash_we_n_out && !flash_data_oe_out)
    else $error("bus driven");
  AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("stray read data");
  AST_BUSY_TRACK: assert property (
    $fell(ready_busy_in_n) |-> ##[2:4] busy_out)
    else $error("busy not seen");
  AST_START_READ: assert property (
    wr_in && addr_in == REG_CTRL && wdata_in[1:0] != 2'b00
    |-> ##[1:3] !flash_ce_n_out)
    else $error("no read after start");
endmodule
bind fwsp_host fwsp_monitor mon (.*);

/* File: fwsp_pkg.sv */
// Constants for the flash status polling controller.
// Assumes a parallel NOR flash with asynchronous read and write cycles.
package fwsp_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 8;
  // Register indices of the command port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_LAST = 4'h4;
  // Control bit positions
  localparam int unsigned CTRL_POLL = 0;
  localparam int unsigned CTRL_TOGGLE = 1;
  localparam int unsigned CTRL_ABORT = 2;
  // Status bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_FAIL = 2;
  localparam int unsigned ST_RDY = 3;
  localparam int unsigned ST_ERTIMER = 4;
  localparam int unsigned ST_ABORTBIT = 5;
  // Flash data bit positions
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOGGLE_ONE_BIT = 6;
  localparam int unsigned TIMEOUT_BIT = 5;
  localparam int unsigned ERASE_TIMER_BIT = 3;
  localparam int unsigned TOGGLE_TWO_BIT = 2;
  localparam int unsigned ABORT_BIT = 1;
  // Flash read cycle timing
  localparam int unsigned READ_ACCESS_NS = 100;
  localparam int unsigned PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int unsigned READ_CYCLES =
    (READ_ACCESS_NS + PERIOD_NS - 1) / PERIOD_NS + 1;
  localparam int unsigned RECOVER_CYCLES = 1;
  typedef enum logic [2:0] {
    FWSP_IDLE = 3'b000,
    FWSP_SETUP = 3'b001,
    FWSP_STROBE = 3'b011,
    FWSP_RECOVER = 3'b010,
    FWSP_EVAL = 3'b110
  } fwsp_state_type;
  typedef enum logic [1:0] {
    FWSP_MODE_POLL = 2'b00,
    FWSP_MODE_TOGGLE = 2'b01
  } fwsp_mode_type;
endpackage
